// ==== dv/ee_partner.sv ====
// Purpose: Far-side model of the EEPROM load engine seen by the reset sequencer.
// Assumes: One load per rising edge of ee_start, answered after DELAY cycles.
// Notes: ee_error_addr toggles while no error is shown, so a stale value never passes.
module ee_partner #(
  parameter int DELAY = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ee_start,
  input wire logic err_mode,
  input wire logic [7:0] err_addr,
  output logic ee_done,
  output logic ee_error,
  output logic [7:0] ee_error_addr,
  output int loads
);
  int cnt;
  // ---------------------------------------------------------------
  // Load engine
  // ---------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      loads <= 0;
      ee_done <= 1'b0;
      ee_error <= 1'b0;
      ee_error_addr <= 8'h00;
    end else begin
      ee_done <= 1'b0;
      ee_error <= 1'b0;
      ee_error_addr <= ~ee_error_addr;
      if (!ee_start) cnt <= 0;
      else if (cnt <= DELAY) cnt <= cnt + 1;
      if (ee_start && cnt == 0) loads <= loads + 1;
      // A short fixed delay keeps every load far inside its time budget.
      if (ee_start && cnt == DELAY) begin
        ee_error <= err_mode;
        ee_done <= !err_mode;
        if (err_mode) ee_error_addr <= err_addr;
      end
    end
  end
endmodule // ee_partner

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the switch reset sequencer.
// Assumes: 50 MHz clock; short training and retry counts.
// Notes: Expected values come from a small model of loads, modes and registers.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, fundamental_reset_n = 1'b1;
  logic [3:0] mode_strap = 4'h1, addr_strap = 4'h0, reg_addr = 4'h0;
  logic hold_strap = 1'b0, slow_strap = 1'b1, ts1_hot = 1'b0, dl_down = 1'b0;
  logic [7:0] link_up = 8'h00, err_addr = 8'h00, ee_error_addr, send_hot_ts1;
  logic ee_done, ee_error, err_mode = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'hD16486F4;
  logic reg_wack, core_reset, pll_enable, link_train, stack_retry, ee_start;
  logic slave_smbus_enable, master_smbus_enable, master_smbus_tick;
  logic [3:0] slave_smbus_address, operating_mode, exp_mode;
  logic [3:0] modes [3] = '{4'hA, 4'hB, 4'h0};
  int fails = 0, checks_done = 0, loads, exp_loads;
  // ---------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------
  switch_reset_sequencer #(.PORTS(8), .TRAIN_CYCLES(50), .RETRY_CYCLES(100)) i_dut (
    .clk(clk), .reset(reset), .fundamental_reset_n(fundamental_reset_n),
    .operating_mode_strap(mode_strap), .reset_hold_strap(hold_strap),
    .master_smbus_slow_strap(slow_strap), .slave_smbus_address_strap(addr_strap),
    .upstream_ts1_hot(ts1_hot), .upstream_dl_down(dl_down), .downstream_link_up(link_up),
    .ee_done(ee_done), .ee_error(ee_error), .ee_error_addr(ee_error_addr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_wack(reg_wack), .core_reset(core_reset),
    .pll_enable(pll_enable), .link_train(link_train), .stack_retry(stack_retry),
    .send_hot_ts1(send_hot_ts1), .slave_smbus_enable(slave_smbus_enable),
    .slave_smbus_address(slave_smbus_address), .master_smbus_enable(master_smbus_enable),
    .master_smbus_tick(master_smbus_tick), .ee_start(ee_start),
    .operating_mode(operating_mode));
  ee_partner #(.DELAY(20)) i_ee (.clk(clk), .reset(reset), .ee_start(ee_start),
    .err_mode(err_mode), .err_addr(err_addr), .ee_done(ee_done), .ee_error(ee_error),
    .ee_error_addr(ee_error_addr), .loads(loads));
  always #10 clk = ~clk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1 chk({31'h0, reg_wack}, 32'h1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wait_core(input logic lvl, input int lim);
    int n;
    n = 0;
    while (core_reset !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    chk({31'h0, core_reset}, {31'h0, lvl});
  endtask
  task automatic tick_per(input int exp);
    int n;
    n = 0;
    while (master_smbus_tick !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (master_smbus_tick !== 1'b1 && n < 1000);
    chk(n, exp);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    #400000;
    fails++;
    test_done();
  end
  initial begin
    addr_strap = rnd();
    exp_mode = 4'h1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    wait_core(1'b0, 400);
    chk(loads, 1);
    chk(operating_mode, exp_mode);
    chk(slave_smbus_address, addr_strap);
    chk({pll_enable, link_train, slave_smbus_enable, master_smbus_enable}, 4'hF);
    tick_per(500);
    rd(4'h2, 32'h1);
    rd(4'h1, {24'h0, exp_mode, 4'h0});
    reg_wdata <= rnd();
    wr(4'h3, 32'h0000_5A5A);
    rd(4'h3, 32'h0000_5A5A);
    rd(4'h9, 32'h0);
    // Hot reset from the link, with the reload disabled.
    wr(4'h0, 32'h10);
    @(posedge clk);
    link_up <= rnd();
    ts1_hot <= 1'b1;
    wait_core(1'b1, 10);
    chk(send_hot_ts1, link_up);
    chk({pll_enable, slave_smbus_enable, master_smbus_enable}, 3'h7);
    wr(4'h3, 32'h0000_1234);
    rd(4'h3, 32'h0);
    rd(4'h2, 32'h0);
    @(posedge clk);
    ts1_hot <= 1'b0;
    wait_core(1'b0, 400);
    chk(loads, 1);
    rd(4'h2, 32'h1);
    rd(4'h3, 32'h0);
    // Register hot reset reloads; the write is answered first.
    wr(4'h0, 32'h2);
    chk({31'h0, core_reset}, 32'h0);
    wait_core(1'b1, 10);
    wait_core(1'b0, 400);
    chk(loads, 2);
    // Link-down trigger is suppressed only while disabled.
    wr(4'h0, 32'h8);
    @(posedge clk);
    dl_down <= 1'b1;
    @(posedge clk);
    dl_down <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk({31'h0, core_reset}, 32'h0);
    wr(4'h0, 32'h0);
    @(posedge clk);
    dl_down <= 1'b1;
    @(posedge clk);
    dl_down <= 1'b0;
    wait_core(1'b1, 10);
    wait_core(1'b0, 400);
    chk(loads, 3);
    // Register fundamental reset keeps old straps; the load fails and holds.
    err_addr <= rnd();
    err_mode <= 1'b1;
    mode_strap <= 4'h0;
    wr(4'h0, 32'h1);
    chk({31'h0, core_reset}, 32'h0);
    wait_core(1'b1, 10);
    repeat (300) @(posedge clk);
    #1 chk({31'h0, core_reset}, 32'h1);
    chk({31'h0, stack_retry}, 32'h1);
    chk(operating_mode, exp_mode);
    chk(loads, 4);
    rd(4'h2, {16'h0, err_addr, 8'h03});
    rd(4'h0, 32'h4);
    err_mode <= 1'b0;
    wr(4'h0, 32'h0);
    wait_core(1'b0, 20);
    exp_loads = 4;
    // Pin fundamental resets through the remaining modes.
    foreach (modes[i]) begin
      @(posedge clk);
      fundamental_reset_n <= 1'b0;
      mode_strap <= modes[i];
      hold_strap <= (modes[i] == 4'h0);
      slow_strap <= 1'b0;
      addr_strap <= rnd();
      wait_core(1'b1, 5);
      @(posedge clk);
      fundamental_reset_n <= 1'b1;
      if (modes[i] == 4'h0) begin
        repeat (150) @(posedge clk);
        #1 chk({31'h0, core_reset}, 32'h1);
        rd(4'h1, 32'h1);
        wr(4'h0, 32'h0);
      end
      wait_core(1'b0, 400);
      exp_loads += (modes[i] != 4'h0);
      chk(loads, exp_loads);
      chk(operating_mode, modes[i]);
      chk(slave_smbus_address, addr_strap);
      tick_per(125);
    end
    test_done();
  end
endmodule // testbench

// ==== hw/switch_reset_sequencer.sv ====
// Purpose: Reset sequencer for a multi-port packet switch.
// Assumes: All inputs synchronous to clk; EEPROM engine is outside, driven by start/done.
// Notes: Software reaches registers over a plain port; slave SMBus shares that port.
//
// What this block does
// - Start fundamental reset on reset pin low or full_reset_request write.
// - Latch straps on pin release; register-started reset reuses old values; reset_hold_strap is not latched and is read at every fundamental reset.
// - Decode latched four-bit mode; 0x1 means EEPROM initialisation.
// - Modes 0xA and 0xB also need EEPROM initialisation.
// - Bring up PLL and SerDes, then start training and carry on.
// - Reset-hold strap sets the reset_hold status bit during the sequence.
// - Links reach active training within 20 ms of reset clearing.
// - Within 100 ms stacks answer config with retry, ignore other traffic.
// - Master SMBus runs at 100 kHz with slow strap, else 400 kHz.
// - Release slave SMBus with strap address, then the master SMBus.
// - In EEPROM modes load registers from EEPROM over master SMBus.
// - Load error aborts, sets control reset_hold, records error details.
// - Set eeprom_load_finished on success or on error.
// - While reset_hold set, hold core in reset until agent clears it.
// - Acknowledge a reset-request write before the reset begins.
// - Hot reset on TS1 hot bit, upstream link down or hot_reset_request.
// - linkdown_hot_reset_disable suppresses only the link-down trigger.
// - During hot reset, downstream ports with link up send hot TS1.
// - Hot reset spares PLL, SerDes, SMBus; sticky status fields kept.
// - After hot reset reload EEPROM only in EEPROM modes, unless disabled.
// - During hot reset, reads of reset registers return zero, writes dropped.
module switch_reset_sequencer #(
  parameter int unsigned PORTS = 8,
  parameter int unsigned TRAIN_CYCLES = rst_seq_pkg::TRAIN_CYCLES,
  parameter int unsigned RETRY_CYCLES = rst_seq_pkg::RETRY_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic fundamental_reset_n,
  input wire logic [3:0] operating_mode_strap,
  input wire logic reset_hold_strap,
  input wire logic master_smbus_slow_strap,
  input wire logic [3:0] slave_smbus_address_strap,
  input wire logic upstream_ts1_hot,
  input wire logic upstream_dl_down,
  input wire logic [PORTS-1:0] downstream_link_up,
  input wire logic ee_done,
  input wire logic ee_error,
  input wire logic [7:0] ee_error_addr,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic reg_wack,
  output logic core_reset,
  output logic pll_enable,
  output logic link_train,
  output logic stack_retry,
  output logic [PORTS-1:0] send_hot_ts1,
  output logic slave_smbus_enable,
  output logic [3:0] slave_smbus_address,
  output logic master_smbus_enable,
  output logic master_smbus_tick,
  output logic ee_start,
  output logic [3:0] operating_mode
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic needs_eeprom(input logic [3:0] m);
    needs_eeprom = (m == rst_seq_pkg::MODE_NORMAL_EE) ||
                   (m == rst_seq_pkg::MODE_FAILOVER0_EE) ||
                   (m == rst_seq_pkg::MODE_FAILOVER2_EE);
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  rst_seq_pkg::seq_state_t state_q;
  logic fund_seen_q;
  logic full_req_q;
  logic hot_req_q;
  logic hot_pending_q;
  logic ctl_hold_q;
  logic ctl_ld_dis_q;
  logic ctl_hot_ee_dis_q;
  logic sts_hold_q;
  logic ee_done_flag_q;
  logic ee_err_q;
  logic [7:0] ee_err_addr_q;
  logic [31:0] scratch_q;
  logic slow_q;
  logic [31:0] timer_q;
  logic [15:0] smb_cnt_q;
  logic [4:0] pll_cnt_q;
  logic is_hot_q;
  logic hot_trigger;
  logic in_hot;
  logic wr_ok;

  assign hot_trigger = upstream_ts1_hot ||
                       (upstream_dl_down && !ctl_ld_dis_q) ||
                       hot_pending_q;
  assign in_hot = (state_q == rst_seq_pkg::ST_HOT);
  assign wr_ok = reg_write && !in_hot;

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  // The mode, slow and address straps are only captured on the pin release so a register-started
  // reset keeps the values of the last cold or warm reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fund_seen_q <= 1'b1;
      operating_mode <= 4'h0;
      slow_q <= 1'b0;
      slave_smbus_address <= 4'h0;
    end else begin
      if (!fundamental_reset_n) begin
        fund_seen_q <= 1'b1;
      end else if (fund_seen_q) begin
        fund_seen_q <= 1'b0;
        operating_mode <= operating_mode_strap;
        slow_q <= master_smbus_slow_strap;
        slave_smbus_address <= slave_smbus_address_strap;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= rst_seq_pkg::ST_FUND_WAIT;
      is_hot_q <= 1'b0;
      pll_cnt_q <= 5'h00;
    end else if (!fundamental_reset_n) begin
      state_q <= rst_seq_pkg::ST_FUND_WAIT;
      is_hot_q <= 1'b0;
    end else begin
      case (state_q)
        rst_seq_pkg::ST_FUND_WAIT: begin
          if (!fund_seen_q) begin
            state_q <= rst_seq_pkg::ST_PLL;
            pll_cnt_q <= 5'h00;
          end
        end
        rst_seq_pkg::ST_PLL: begin
          pll_cnt_q <= pll_cnt_q + 5'h01;
          if (pll_cnt_q == 5'(rst_seq_pkg::PLL_LOCK_CYCLES)) begin
            state_q <= rst_seq_pkg::ST_SMB_SLAVE;
          end
        end
        rst_seq_pkg::ST_SMB_SLAVE: state_q <= rst_seq_pkg::ST_SMB_MASTER;
        rst_seq_pkg::ST_SMB_MASTER: begin
          state_q <= needs_eeprom(operating_mode) ? rst_seq_pkg::ST_EE_LOAD
                                                  : rst_seq_pkg::ST_HOLD;
        end
        rst_seq_pkg::ST_EE_LOAD: begin
          if (ee_done || ee_error) begin
            state_q <= rst_seq_pkg::ST_HOLD;
          end
        end
        rst_seq_pkg::ST_HOLD: begin
          if (!ctl_hold_q) begin
            state_q <= rst_seq_pkg::ST_RUN;
          end
        end
        rst_seq_pkg::ST_RUN: begin
          if (full_req_q) begin
            state_q <= rst_seq_pkg::ST_REQ_DELAY;
            is_hot_q <= 1'b0;
          end else if (hot_trigger) begin
            state_q <= rst_seq_pkg::ST_HOT;
            is_hot_q <= 1'b1;
          end
        end
        rst_seq_pkg::ST_REQ_DELAY: state_q <= rst_seq_pkg::ST_FUND_WAIT;
        rst_seq_pkg::ST_HOT: begin
          if (!upstream_ts1_hot) begin
            state_q <= (needs_eeprom(operating_mode) && !ctl_hot_ee_dis_q) ?
                       rst_seq_pkg::ST_EE_LOAD : rst_seq_pkg::ST_HOLD;
          end
        end
        default: state_q <= rst_seq_pkg::ST_FUND_WAIT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Reset domain outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_reset <= 1'b1;
      pll_enable <= 1'b0;
      slave_smbus_enable <= 1'b0;
      master_smbus_enable <= 1'b0;
      ee_start <= 1'b0;
      send_hot_ts1 <= '0;
    end else begin
      core_reset <= (state_q != rst_seq_pkg::ST_RUN);
      pll_enable <= (state_q != rst_seq_pkg::ST_FUND_WAIT) &&
                    (state_q != rst_seq_pkg::ST_REQ_DELAY);
      slave_smbus_enable <= pll_enable && (state_q != rst_seq_pkg::ST_PLL) &&
                            (state_q != rst_seq_pkg::ST_FUND_WAIT);
      master_smbus_enable <= slave_smbus_enable &&
                             (state_q != rst_seq_pkg::ST_SMB_SLAVE) &&
                             (state_q != rst_seq_pkg::ST_FUND_WAIT);
      ee_start <= (state_q == rst_seq_pkg::ST_EE_LOAD) && !ee_done && !ee_error;
      send_hot_ts1 <= in_hot ? downstream_link_up : '0;
    end
  end

  // ---------------------------------------------------------------
  // Link training and retry window
  // ---------------------------------------------------------------
  // Retry begins at once when the reset condition clears and training once the
  // PLL state ends, so both deadlines hold with margin; the timer only feeds the a_train_window check.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_q <= 32'h0000_0000;
      link_train <= 1'b0;
      stack_retry <= 1'b0;
    end else if (state_q == rst_seq_pkg::ST_FUND_WAIT || in_hot ||
                 state_q == rst_seq_pkg::ST_REQ_DELAY) begin
      timer_q <= 32'h0000_0000;
      link_train <= 1'b0;
      stack_retry <= 1'b0;
    end else begin
      if (timer_q != 32'hFFFF_FFFF) begin
        timer_q <= timer_q + 32'h0000_0001;
      end
      if (state_q != rst_seq_pkg::ST_PLL || is_hot_q) begin
        link_train <= 1'b1;
      end
      stack_retry <= (state_q != rst_seq_pkg::ST_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Master SMBus rate divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      smb_cnt_q <= 16'h0000;
      master_smbus_tick <= 1'b0;
    end else if (!master_smbus_enable) begin
      smb_cnt_q <= 16'h0000;
      master_smbus_tick <= 1'b0;
    end else begin
      master_smbus_tick <= 1'b0;
      if (smb_cnt_q == (slow_q ? 16'(rst_seq_pkg::SMB_SLOW_DIV - 1)
                               : 16'(rst_seq_pkg::SMB_FAST_DIV - 1))) begin
        smb_cnt_q <= 16'h0000;
        master_smbus_tick <= 1'b1;
      end else begin
        smb_cnt_q <= smb_cnt_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      full_req_q <= 1'b0;
      hot_req_q <= 1'b0;
      hot_pending_q <= 1'b0;
      ctl_hold_q <= 1'b0;
      ctl_ld_dis_q <= 1'b0;
      ctl_hot_ee_dis_q <= 1'b0;
      reg_wack <= 1'b0;
    end else begin
      reg_wack <= reg_write;
      hot_pending_q <= hot_req_q;
      if (state_q == rst_seq_pkg::ST_FUND_WAIT) begin
        full_req_q <= 1'b0;
        hot_req_q <= 1'b0;
        hot_pending_q <= 1'b0;
        ctl_ld_dis_q <= 1'b0;
        ctl_hot_ee_dis_q <= 1'b0;
        ctl_hold_q <= reset_hold_strap;
      end else if (in_hot) begin
        hot_req_q <= 1'b0;
        hot_pending_q <= 1'b0;
      end else begin
        if (wr_ok && reg_addr == rst_seq_pkg::SWITCH_CONTROL_ADDR) begin
          full_req_q <= reg_wdata[rst_seq_pkg::CTL_FULL_RESET_BIT];
          hot_req_q <= reg_wdata[rst_seq_pkg::CTL_HOT_RESET_BIT];
          ctl_hold_q <= reg_wdata[rst_seq_pkg::CTL_RESET_HOLD_BIT];
          ctl_ld_dis_q <= reg_wdata[rst_seq_pkg::CTL_LINKDOWN_DIS_BIT];
          ctl_hot_ee_dis_q <= reg_wdata[rst_seq_pkg::CTL_HOT_EE_DIS_BIT];
        end
        if (state_q == rst_seq_pkg::ST_EE_LOAD && ee_error) begin
          ctl_hold_q <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------
  // Status bits are sticky across a hot reset; the set wins over a clear.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sts_hold_q <= 1'b0;
      ee_done_flag_q <= 1'b0;
      ee_err_q <= 1'b0;
      ee_err_addr_q <= 8'h00;
      scratch_q <= rst_seq_pkg::SCRATCH_RESET;
    end else if (state_q == rst_seq_pkg::ST_FUND_WAIT) begin
      sts_hold_q <= 1'b0;
      ee_done_flag_q <= 1'b0;
      ee_err_q <= 1'b0;
      ee_err_addr_q <= 8'h00;
      scratch_q <= rst_seq_pkg::SCRATCH_RESET;
    end else begin
      if (in_hot) begin
        scratch_q <= rst_seq_pkg::SCRATCH_RESET;
      end else if (wr_ok && reg_addr == rst_seq_pkg::SCRATCH_ADDR) begin
        scratch_q <= reg_wdata;
      end
      if (wr_ok && reg_addr == rst_seq_pkg::SMBUS_STATUS_ADDR &&
          reg_wdata[rst_seq_pkg::SMB_DONE_BIT]) begin
        ee_done_flag_q <= 1'b0;
      end
      if (state_q == rst_seq_pkg::ST_EE_LOAD && (ee_done || ee_error)) begin
        ee_done_flag_q <= 1'b1;
      end
      if (state_q == rst_seq_pkg::ST_EE_LOAD && ee_error) begin
        ee_err_q <= 1'b1;
        ee_err_addr_q <= ee_error_addr;
      end
      if (state_q == rst_seq_pkg::ST_PLL && reset_hold_strap) begin
        sts_hold_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_read || in_hot) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        rst_seq_pkg::SWITCH_CONTROL_ADDR: begin
          reg_rdata <= {27'h0, ctl_hot_ee_dis_q, ctl_ld_dis_q, ctl_hold_q, 2'b00};
        end
        rst_seq_pkg::SWITCH_STATUS_ADDR: begin
          reg_rdata <= {24'h0, operating_mode, 3'b000, sts_hold_q};
        end
        rst_seq_pkg::SMBUS_STATUS_ADDR: begin
          reg_rdata <= {16'h0, ee_err_addr_q, 6'h00, ee_err_q, ee_done_flag_q};
        end
        rst_seq_pkg::SCRATCH_ADDR: reg_rdata <= scratch_q;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_ee_error_hold: assert property (@(posedge clk) disable iff (reset)
    (state_q == rst_seq_pkg::ST_EE_LOAD && ee_error && fundamental_reset_n)
      |=> ctl_hold_q && ee_done_flag_q)
    else $error("EEPROM error did not set hold and done.");
  a_hold_core_reset: assert property (@(posedge clk) disable iff (reset)
    (state_q == rst_seq_pkg::ST_HOLD) |=> core_reset)
    else $error("Core left reset while hold active.");
  a_hot_zero_read: assert property (@(posedge clk) disable iff (reset)
    (in_hot && reg_read) |=> reg_rdata == 32'h0000_0000)
    else $error("Read during hot reset returned data.");
  a_hot_ts1_ports: assert property (@(posedge clk) disable iff (reset)
    in_hot |=> send_hot_ts1 == $past(downstream_link_up))
    else $error("Hot TS1 not sent on up links.");
  a_full_req_ack: assert property (@(posedge clk) disable iff (reset)
    (state_q == rst_seq_pkg::ST_REQ_DELAY) |-> $past(reg_wack) || reg_wack)
    else $error("Reset began before write acknowledge.");
  a_smb_order: assert property (@(posedge clk) disable iff (reset)
    master_smbus_enable |-> slave_smbus_enable)
    else $error("Master SMBus released before slave.");
  a_mode_ee_decode: assert property (@(posedge clk) disable iff (reset)
    (state_q == rst_seq_pkg::ST_SMB_MASTER && fundamental_reset_n &&
     operating_mode == rst_seq_pkg::MODE_FAILOVER2_EE)
      |=> state_q == rst_seq_pkg::ST_EE_LOAD)
    else $error("Mode 0xB skipped EEPROM load.");
  a_train_deadline: assert property (@(posedge clk) disable iff (reset)
    (state_q == rst_seq_pkg::ST_SMB_SLAVE) |=> link_train)
    else $error("Training not started after PLL.");
  a_train_window: assert property (@(posedge clk) disable iff (reset)
    (timer_q == TRAIN_CYCLES) |-> link_train)
    else $error("Training not active at the training deadline.");
endmodule // switch_reset_sequencer

// ==== shared/rst_seq_pkg.sv ====
// Purpose: Constants shared by the switch reset sequencer.
// Assumes: One 50 MHz core clock.
// Notes: Register offsets are word indices on the plain register port.
package rst_seq_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned TRAIN_LIMIT_MS = 20;
  localparam int unsigned RETRY_LIMIT_MS = 100;
  localparam int unsigned TRAIN_CYCLES = TRAIN_LIMIT_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYCLES = RETRY_LIMIT_MS * (CLK_HZ / 1000);
  localparam int unsigned SMB_SLOW_HZ = 100000;
  localparam int unsigned SMB_FAST_HZ = 400000;
  localparam int unsigned SMB_SLOW_DIV = CLK_HZ / SMB_SLOW_HZ;
  localparam int unsigned SMB_FAST_DIV = CLK_HZ / SMB_FAST_HZ;
  localparam int unsigned PLL_LOCK_CYCLES = 16;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] SWITCH_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] SWITCH_STATUS_ADDR = 4'h1;
  localparam logic [3:0] SMBUS_STATUS_ADDR = 4'h2;
  localparam logic [3:0] SCRATCH_ADDR = 4'h3;
  // switch_control fields
  localparam int unsigned CTL_FULL_RESET_BIT = 0;
  localparam int unsigned CTL_HOT_RESET_BIT = 1;
  localparam int unsigned CTL_RESET_HOLD_BIT = 2;
  localparam int unsigned CTL_LINKDOWN_DIS_BIT = 3;
  localparam int unsigned CTL_HOT_EE_DIS_BIT = 4;
  // switch_status fields
  localparam int unsigned STS_RESET_HOLD_BIT = 0;
  localparam int unsigned STS_MODE_LSB = 4;
  // smbus_status fields
  localparam int unsigned SMB_DONE_BIT = 0;
  localparam int unsigned SMB_ERR_BIT = 1;
  localparam int unsigned SMB_ERR_ADDR_LSB = 8;
  localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Operating mode codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL_EE = 4'h1;
  localparam logic [3:0] MODE_FAILOVER0_EE = 4'hA;
  localparam logic [3:0] MODE_FAILOVER2_EE = 4'hB;

  typedef enum logic [8:0] {
    ST_FUND_WAIT = 9'h001,
    ST_PLL = 9'h002,
    ST_SMB_SLAVE = 9'h004,
    ST_SMB_MASTER = 9'h008,
    ST_EE_LOAD = 9'h010,
    ST_HOLD = 9'h020,
    ST_RUN = 9'h040,
    ST_HOT = 9'h080,
    ST_REQ_DELAY = 9'h100
  } seq_state_t;
endpackage
